// >>> uos_defines.vh
`ifndef UOS_DEFINES_VH
`define UOS_DEFINES_VH
// register byte addresses (word aligned)
`define UOS_ADDR_EP3_DATA   8'h00
`define UOS_ADDR_EP4_DATA   8'h04
`define UOS_ADDR_SESS_CTRL  8'h08
// session control field positions
`define UOS_B_ROLE_BIT      7
`define UOS_FULL_SPEED_BIT  6
`define UOS_LOW_SPEED_BIT   5
`define UOS_VBUS_HI_BIT     4
`define UOS_VBUS_LO_BIT     3
`define UOS_HOST_BIT        2
`define UOS_NEG_REQ_BIT     1
`define UOS_SESSION_BIT     0
// reset values
`define UOS_SESS_CTRL_RST   8'h00
`define UOS_DATA_RST        32'h0000_0000
// vbus band encodings
`define UOS_VBUS_BELOW_END  2'h0
`define UOS_VBUS_ABOVE_END  2'h1
`define UOS_VBUS_ABOVE_AVLD 2'h2
`define UOS_VBUS_ABOVE_VVLD 2'h3
// fifo depth
`define UOS_FIFO_DEPTH      8
`endif

// >>> uos_fifo.v
`timescale 1ns/1ns
`default_nettype none
module uos_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // clock and reset
   input  wire             core_clk_i,
   input  wire             rst_n_i,
   // fill side
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   // drain side
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o,
   // level
   output wire [AW:0]      level_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;
   integer         i;

   assign in_ready_o  = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_ptr];
   assign level_o     = count;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] <= {WIDTH{1'b0}};
         end
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data_i;
            wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // uos_fifo
`default_nettype wire

// >>> uos_session_ports.v
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "uos_defines.vh"
module uos_session_ports #(
   parameter DATA_W     = 32,
   parameter FIFO_DEPTH = `UOS_FIFO_DEPTH,
   parameter FIFO_AW    = 3
) (
   // clock and reset
   input  wire              core_clk_i,
   input  wire              rst_n_i,
   // avalon-mm slave
   input  wire [7:0]        avs_address_i,
   input  wire              avs_read_i,
   input  wire              avs_write_i,
   input  wire [DATA_W-1:0] avs_writedata_i,
   input  wire [3:0]        avs_byteenable_i,
   output reg  [DATA_W-1:0] avs_readdata_o,
   output wire              avs_waitrequest_o,
   // transmit fifo drain (protocol engine side), endpoints 3 and 4
   output wire              ep3_tx_valid_o,
   input  wire              ep3_tx_ready_i,
   output wire [DATA_W-1:0] ep3_tx_data_o,
   output wire              ep4_tx_valid_o,
   input  wire              ep4_tx_ready_i,
   output wire [DATA_W-1:0] ep4_tx_data_o,
   // receive fifo fill (protocol engine side), endpoints 3 and 4
   input  wire              ep3_rx_valid_i,
   output wire              ep3_rx_ready_o,
   input  wire [DATA_W-1:0] ep3_rx_data_i,
   input  wire              ep4_rx_valid_i,
   output wire              ep4_rx_ready_o,
   input  wire [DATA_W-1:0] ep4_rx_data_i,
   // link status from the phy and line state logic (asynchronous pins)
   input  wire              b_role_pin_i,
   input  wire              host_active_pin_i,
   input  wire              suspended_pin_i,
   input  wire              attach_pin_i,
   input  wire              low_speed_line_pin_i,
   input  wire              chirp_seen_pin_i,
   input  wire              session_valid_pin_i,
   input  wire [1:0]        vbus_band_pin_i,
   input  wire              negotiation_done_pin_i,
   // requests toward the line logic
   output reg               session_request_o,
   output reg               negotiation_start_o,
   output reg               soft_disconnect_o,
   output reg               high_speed_attached_o
);
   // ************************************************************
   // pin synchronisers: three stages, change accepted when 2 and 3 agree
   // ************************************************************
   localparam NPIN = 10;
   wire [NPIN-1:0] pin_raw;
   reg  [NPIN-1:0] sync_a;
   reg  [NPIN-1:0] sync_b;
   reg  [NPIN-1:0] sync_c;
   reg  [NPIN-1:0] pin;
   assign pin_raw = {negotiation_done_pin_i, vbus_band_pin_i, session_valid_pin_i, chirp_seen_pin_i,
                     low_speed_line_pin_i, attach_pin_i, suspended_pin_i, host_active_pin_i, b_role_pin_i};

   genvar g;
   generate
      for (g = 0; g < NPIN; g = g + 1) begin : g_sync
         always @(posedge core_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               sync_a[g] <= 1'b0;
               sync_b[g] <= 1'b0;
               sync_c[g] <= 1'b0;
               pin[g]    <= 1'b0;
            end else begin
               sync_a[g] <= pin_raw[g];
               sync_b[g] <= sync_a[g];
               sync_c[g] <= sync_b[g];
               if (sync_b[g] == sync_c[g]) begin
                  pin[g] <= sync_c[g];
               end
            end
         end
      end
   endgenerate

   wire       b_role_flag      = pin[0];
   wire       acting_host_flag = pin[1];
   wire       suspended        = pin[2];
   wire       attached         = pin[3];
   wire       low_speed_line   = pin[4];
   wire       chirp_seen       = pin[5];
   wire       session_valid    = pin[6];
   wire [1:0] vbus_band        = pin[8:7];
   wire       negotiation_done = pin[9];

   // ************************************************************
   // address decode
   // ************************************************************
   function [2:0] uos_decode;
      input [7:0] addr;
      begin
         uos_decode = 3'b000;
         case (addr)
            `UOS_ADDR_EP3_DATA:  uos_decode = 3'b001;
            `UOS_ADDR_EP4_DATA:  uos_decode = 3'b010;
            `UOS_ADDR_SESS_CTRL: uos_decode = 3'b100;
            default:             uos_decode = 3'b000;
         endcase
      end
   endfunction

   wire [2:0] sel = uos_decode(avs_address_i);

   // ************************************************************
   // bus state machine: idle, then one answer cycle
   // ************************************************************
   localparam ST_IDLE = 2'b01;
   localparam ST_DONE = 2'b10;
   reg [1:0] state;
   reg [1:0] next_state;

   wire req       = avs_read_i | avs_write_i;
   // a full tx fifo stalls the write, so back-pressure reaches software
   wire ep3_tx_in_ready;
   wire ep4_tx_in_ready;
   wire ep3_rx_out_valid;
   wire ep4_rx_out_valid;
   wire [DATA_W-1:0] ep3_rx_word;
   wire [DATA_W-1:0] ep4_rx_word;
   wire stall_wr  = avs_write_i & ((sel[0] & ~ep3_tx_in_ready) | (sel[1] & ~ep4_tx_in_ready));
   wire accept    = (state == ST_IDLE) & req & ~stall_wr;

   assign avs_waitrequest_o = ~(state == ST_DONE);

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (accept) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   wire wr_ep3 = accept & avs_write_i & sel[0];
   wire wr_ep4 = accept & avs_write_i & sel[1];
   // empty receive fifo reads as zero and pops nothing
   wire rd_ep3 = accept & avs_read_i & sel[0];
   wire rd_ep4 = accept & avs_read_i & sel[1];
   wire wr_ctl = accept & avs_write_i & sel[2] & avs_byteenable_i[0];

   // ************************************************************
   // endpoint fifos
   // ************************************************************
   uos_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_ep3_tx (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (wr_ep3),
      .in_ready_o  (ep3_tx_in_ready),
      .in_data_i   (avs_writedata_i),
      .out_valid_o (ep3_tx_valid_o),
      .out_ready_i (ep3_tx_ready_i),
      .out_data_o  (ep3_tx_data_o),
      .level_o     ()
   );
   uos_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_ep4_tx (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (wr_ep4),
      .in_ready_o  (ep4_tx_in_ready),
      .in_data_i   (avs_writedata_i),
      .out_valid_o (ep4_tx_valid_o),
      .out_ready_i (ep4_tx_ready_i),
      .out_data_o  (ep4_tx_data_o),
      .level_o     ()
   );
   uos_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_ep3_rx (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (ep3_rx_valid_i),
      .in_ready_o  (ep3_rx_ready_o),
      .in_data_i   (ep3_rx_data_i),
      .out_valid_o (ep3_rx_out_valid),
      .out_ready_i (rd_ep3),
      .out_data_o  (ep3_rx_word),
      .level_o     ()
   );
   uos_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_ep4_rx (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (ep4_rx_valid_i),
      .in_ready_o  (ep4_rx_ready_o),
      .in_data_i   (ep4_rx_data_i),
      .out_valid_o (ep4_rx_out_valid),
      .out_ready_i (rd_ep4),
      .out_data_o  (ep4_rx_word),
      .level_o     ()
   );

   // ************************************************************
   // session control state
   // ************************************************************
   reg       full_speed_attached;
   reg       low_speed_attached;
   reg       negotiation_request;
   reg       session;
   reg       suspended_q;
   reg       b_role_q;
   reg       session_valid_q;
   wire      suspend_rise = suspended & ~suspended_q;
   wire      b_sess_start = b_role_flag & session_valid & ~session_valid_q;
   wire      b_sess_end   = b_role_flag & ~session_valid & session_valid_q;
   wire      sw_sess_set  = wr_ctl & avs_writedata_i[`UOS_SESSION_BIT] & ~session;
   wire      sw_sess_clr  = wr_ctl & ~avs_writedata_i[`UOS_SESSION_BIT] & session;

   wire [7:0] sess_ctrl_rd = {b_role_flag,
                              full_speed_attached,
                              low_speed_attached,
                              vbus_band,
                              acting_host_flag,
                              negotiation_request,
                              session};

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state                 <= ST_IDLE;
         avs_readdata_o        <= `UOS_DATA_RST;
         full_speed_attached   <= 1'b0;
         low_speed_attached    <= 1'b0;
         high_speed_attached_o <= 1'b0;
         negotiation_request   <= 1'b0;
         session               <= 1'b0;
         suspended_q           <= 1'b0;
         b_role_q              <= 1'b0;
         session_valid_q       <= 1'b0;
         session_request_o     <= 1'b0;
         negotiation_start_o   <= 1'b0;
         soft_disconnect_o     <= 1'b0;
      end else begin
         state           <= next_state;
         suspended_q     <= suspended;
         b_role_q        <= b_role_flag;
         session_valid_q <= session_valid;

         // read data
         if (accept && avs_read_i) begin
            if (sel[0]) begin
               avs_readdata_o <= ep3_rx_out_valid ? ep3_rx_word : `UOS_DATA_RST;
            end else if (sel[1]) begin
               avs_readdata_o <= ep4_rx_out_valid ? ep4_rx_word : `UOS_DATA_RST;
            end else if (sel[2]) begin
               avs_readdata_o <= {{(DATA_W-8){1'b0}}, sess_ctrl_rd};
            end else begin
               avs_readdata_o <= `UOS_DATA_RST;
            end
         end

         // speed of attached peripheral, only tracked while host
         if (acting_host_flag && attached) begin
            low_speed_attached    <= low_speed_line;
            full_speed_attached   <= ~low_speed_line;
            if (chirp_seen && !low_speed_line) begin
               high_speed_attached_o <= 1'b1;
            end
         end else begin
            low_speed_attached    <= 1'b0;
            full_speed_attached   <= 1'b0;
            high_speed_attached_o <= 1'b0;
         end

         // negotiation request: completion clear wins over a same-cycle write
         negotiation_start_o <= 1'b0;
         if (negotiation_done) begin
            negotiation_request <= 1'b0;
         end else if (wr_ctl) begin
            negotiation_request <= avs_writedata_i[`UOS_NEG_REQ_BIT];
         end
         if (b_role_flag && negotiation_request && suspend_rise) begin
            negotiation_start_o <= 1'b1;
         end

         // session bit
         session_request_o <= 1'b0;
         soft_disconnect_o <= 1'b0;
         if (b_sess_start) begin
            session <= 1'b1;
         end else if (b_sess_end) begin
            session <= 1'b0;
         end else if (sw_sess_set) begin
            session           <= 1'b1;
            session_request_o <= b_role_flag;
         end else if (sw_sess_clr) begin
            session           <= 1'b0;
            soft_disconnect_o <= suspended;
         end else if (b_role_flag != b_role_q) begin
            session <= 1'b0;
         end
      end
   end
endmodule // uos_session_ports
`default_nettype wire

// >>> uos_session_ports_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module uos_session_ports_asserts #(
   parameter DATA_W = 32
) (
   // clock and reset
   input wire logic              core_clk_i,
   input wire logic              rst_n_i,
   // register bus
   input wire logic              avs_read_i,
   input wire logic              avs_waitrequest_o,
   // transmit drain, endpoint 3
   input wire logic              ep3_tx_valid_o,
   input wire logic              ep3_tx_ready_i,
   input wire logic [DATA_W-1:0] ep3_tx_data_o,
   // link status and requests
   input wire logic              b_role_pin_i,
   input wire logic              host_active_pin_i,
   input wire logic              suspended_pin_i,
   input wire logic              session_request_o,
   input wire logic              negotiation_start_o,
   input wire logic              soft_disconnect_o,
   input wire logic              high_speed_attached_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ****************
   // bus answer and fifo head
   // ****************
   property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low for more than one cycle");
   property p_rd_ans; avs_read_i && avs_waitrequest_o |-> ##1 !avs_waitrequest_o; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered in the next cycle");
   property p_tx_hold; ep3_tx_valid_o && !ep3_tx_ready_i |=> ep3_tx_valid_o && $stable(ep3_tx_data_o); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("stalled transmit word changed or vanished");
   // ****************
   // session requests and high-speed flag
   // ****************
   property p_req_pulse; session_request_o |=> !session_request_o; endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("session request longer than one cycle");
   property p_disc_pulse; soft_disconnect_o |=> !soft_disconnect_o; endproperty
   a_disc_pulse: assert property (p_disc_pulse) else $error("disconnect longer than one cycle");
   property p_req_role; !b_role_pin_i [*8] |-> !session_request_o; endproperty
   a_req_role: assert property (p_req_role) else $error("session request outside b role");
   property p_disc_susp; !suspended_pin_i [*8] |-> !soft_disconnect_o; endproperty
   a_disc_susp: assert property (p_disc_susp) else $error("disconnect while not suspended");
   property p_neg_susp; !suspended_pin_i [*8] |-> !negotiation_start_o; endproperty
   a_neg_susp: assert property (p_neg_susp) else $error("negotiation started without suspend");
   property p_hs_host; !host_active_pin_i [*8] |-> !high_speed_attached_o; endproperty
   a_hs_host: assert property (p_hs_host) else $error("high speed flag outside host role");
   c_req: cover property (session_request_o);
   c_neg: cover property (negotiation_start_o);
   c_disc: cover property (soft_disconnect_o);
endmodule // uos_session_ports_asserts
bind uos_session_ports uos_session_ports_asserts #(.DATA_W(DATA_W)) uos_session_ports_asserts_inst (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_waitrequest_o(avs_waitrequest_o),
   .ep3_tx_valid_o(ep3_tx_valid_o), .ep3_tx_ready_i(ep3_tx_ready_i), .ep3_tx_data_o(ep3_tx_data_o),
   .b_role_pin_i(b_role_pin_i), .host_active_pin_i(host_active_pin_i), .suspended_pin_i(suspended_pin_i),
   .session_request_o(session_request_o), .negotiation_start_o(negotiation_start_o),
   .soft_disconnect_o(soft_disconnect_o), .high_speed_attached_o(high_speed_attached_o));
`default_nettype wire

// >>> uos_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module uos_far_model (
   // clock and stall control
   input  wire logic             core_clk_i,
   input  wire logic             stall_i,
   // transmit drain, index 0 is endpoint 3
   input  wire logic [1:0]       tx_valid_i,
   output wire logic [1:0]       tx_ready_o,
   input  wire logic [1:0][31:0] tx_data_i,
   // receive fill
   output var  logic [1:0]       rx_valid_o,
   input  wire logic [1:0]       rx_ready_i,
   output var  logic [1:0][31:0] rx_data_o
);
   logic [31:0] got [1:0][$];
   initial begin
      rx_valid_o = 2'h0;
      rx_data_o  = '0;
   end
   assign tx_ready_o = stall_i ? 2'h0 : 2'h3;
   always @(posedge core_clk_i) begin
      for (int e = 0; e < 2; e++) begin
         if (tx_valid_i[e] === 1'b1 && tx_ready_o[e]) got[e].push_back(tx_data_i[e]);
      end
   end
   // the data line flips after release so a stale word is never mistaken for a fresh one
   task automatic send(input int e, input logic [31:0] w);
      @(posedge core_clk_i);
      rx_data_o[e] <= w;
      rx_valid_o[e] <= 1'b1;
      do @(posedge core_clk_i); while (rx_ready_i[e] !== 1'b1);
      rx_valid_o[e] <= 1'b0;
      rx_data_o[e] <= ~w;
   endtask
endmodule // uos_far_model
`default_nettype wire

// >>> uos_session_ports_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module uos_session_ports_tb_top;
   // ****************
   // signals
   // ****************
   logic             core_clk_i = 1'b0;
   logic             rst_n_i = 1'b0;
   logic [7:0]       adr = 8'h00;
   logic             rd = 1'b0;
   logic             wr = 1'b0;
   logic [31:0]      wdat = 32'h0000_0000;
   logic [31:0]      q;
   logic             stall = 1'b1;
   logic             brole = 1'b0, host = 1'b0, susp = 1'b0, att = 1'b0, ls = 1'b0, chirp = 1'b0, sv = 1'b0, nd = 1'b0;
   logic [1:0]       vb = 2'h0;
   wire  [31:0]      rdat;
   wire              wreq, sreq, nstart, sdisc, hs;
   wire  [1:0]       tval, trdy, rval, rrdy;
   wire  [1:0][31:0] tdat, rxd;
   int               err_total = 0, n_compared = 0, n_req = 0, n_neg = 0, n_disc = 0, cyc = 0;
   always #2 core_clk_i = ~core_clk_i;
   uos_session_ports uos_session_ports_inst (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .ep3_tx_valid_o(tval[0]), .ep3_tx_ready_i(trdy[0]), .ep3_tx_data_o(tdat[0]),
      .ep4_tx_valid_o(tval[1]), .ep4_tx_ready_i(trdy[1]), .ep4_tx_data_o(tdat[1]),
      .ep3_rx_valid_i(rval[0]), .ep3_rx_ready_o(rrdy[0]), .ep3_rx_data_i(rxd[0]),
      .ep4_rx_valid_i(rval[1]), .ep4_rx_ready_o(rrdy[1]), .ep4_rx_data_i(rxd[1]),
      .b_role_pin_i(brole), .host_active_pin_i(host), .suspended_pin_i(susp), .attach_pin_i(att),
      .low_speed_line_pin_i(ls), .chirp_seen_pin_i(chirp), .session_valid_pin_i(sv), .vbus_band_pin_i(vb),
      .negotiation_done_pin_i(nd), .session_request_o(sreq), .negotiation_start_o(nstart),
      .soft_disconnect_o(sdisc), .high_speed_attached_o(hs));
   uos_far_model uos_far_model_inst (.core_clk_i(core_clk_i), .stall_i(stall), .tx_valid_i(tval),
      .tx_ready_o(trdy), .tx_data_i(tdat), .rx_valid_o(rval), .rx_ready_i(rrdy), .rx_data_o(rxd));
   // ****************
   // tasks
   // ****************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      adr <= a;
      rd <= ~w;
      wr <= w;
      wdat <= d;
      do @(posedge core_clk_i); while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, exp, q);
   endtask
   // pins pass a synchroniser, so give them time to land in the register
   task automatic settle;
      repeat (8) @(posedge core_clk_i);
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cyc++;
      if (sreq === 1'b1) n_req++;
      if (nstart === 1'b1) n_neg++;
      if (sdisc === 1'b1) n_disc++;
      if (cyc == 6000) begin
         err_total++;
         stop_test();
      end
   end
   // ****************
   // tests
   // ****************
   initial begin
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      rchk("ctrl_rst", 8'h08, 32'h0000_0000);
      rchk("ep4_rst", 8'h04, 32'h0000_0000);
      bus(1'b1, 8'h0c, 32'hffff_ffff);
      rchk("unmapped", 8'h0c, 32'h0000_0000);
      fork
         for (int i = 0; i < 9; i++) bus(1'b1, 8'h00, 32'ha000_0000 + i);
         begin
            repeat (60) @(posedge core_clk_i);
            stall <= 1'b0;
         end
      join
      bus(1'b1, 8'h04, 32'hb000_0004);
      // the ninth word leaves the fifo only after eight pops, so leave ample margin
      repeat (16) @(posedge core_clk_i);
      chk("tx3_count", 9, uos_far_model_inst.got[0].size());
      for (int i = 0; i < 9; i++) chk("tx3_word", 32'ha000_0000 + i, uos_far_model_inst.got[0][i]);
      chk("tx4_word", 32'hb000_0004, uos_far_model_inst.got[1][0]);
      fork
         for (int i = 0; i < 9; i++) uos_far_model_inst.send(0, 32'hc000_0000 + i);
      join_none
      uos_far_model_inst.send(1, 32'hd000_0001);
      repeat (30) @(posedge core_clk_i);
      chk("rx3_full", 0, rrdy[0]);
      for (int i = 0; i < 9; i++) rchk("rx3_word", 8'h00, 32'hc000_0000 + i);
      rchk("rx4_word", 8'h04, 32'hd000_0001);
      rchk("rx3_empty", 8'h00, 32'h0000_0000);
      for (int b = 0; b < 4; b++) begin
         vb <= b[1:0];
         settle();
         rchk("vbus_band", 8'h08, {27'h0, b[1:0], 3'h0});
      end
      host <= 1'b1;
      att <= 1'b1;
      ls <= 1'b1;
      settle();
      rchk("low_speed", 8'h08, 32'h0000_003c);
      ls <= 1'b0;
      chirp <= 1'b1;
      settle();
      rchk("full_speed", 8'h08, 32'h0000_005c);
      chk("high_speed", 1, hs);
      host <= 1'b0;
      att <= 1'b0;
      chirp <= 1'b0;
      brole <= 1'b1;
      sv <= 1'b1;
      settle();
      chk("high_speed_off", 0, hs);
      rchk("b_session", 8'h08, 32'h0000_0099);
      sv <= 1'b0;
      settle();
      rchk("b_sess_end", 8'h08, 32'h0000_0098);
      bus(1'b1, 8'h08, 32'h0000_0001);
      bus(1'b1, 8'h08, 32'h0000_0002);
      repeat (4) @(posedge core_clk_i);
      chk("srp_pulse", 1, n_req);
      rchk("neg_req", 8'h08, 32'h0000_009a);
      susp <= 1'b1;
      settle();
      chk("neg_start", 1, n_neg);
      nd <= 1'b1;
      settle();
      rchk("neg_clear", 8'h08, 32'h0000_0098);
      susp <= 1'b0;
      nd <= 1'b0;
      brole <= 1'b0;
      settle();
      bus(1'b1, 8'h08, 32'h0000_0001);
      rchk("a_session", 8'h08, 32'h0000_0019);
      chk("srp_a_none", 1, n_req);
      susp <= 1'b1;
      settle();
      bus(1'b1, 8'h08, 32'h0000_0000);
      repeat (4) @(posedge core_clk_i);
      chk("disconnect", 1, n_disc);
      rchk("a_sess_end", 8'h08, 32'h0000_0018);
      stop_test();
   end
endmodule // uos_session_ports_tb_top
`default_nettype wire
